// ### shared/iolp_pkg.sv
// Shared constants for the I/O sampling and line passing block
package iolp_pkg;
    localparam int NPIN = 13;
    localparam int CLK_NS = 8;
    localparam int MS_NS = 1_000_000;
    localparam int MS_CYC = MS_NS / CLK_NS;
    localparam int HOLD_REF_MS = 10_000;
    localparam logic [7:0] HOLD_REF_SET = 8'h64;
    localparam int HOLD_UNIT_MS = HOLD_REF_MS / int'(HOLD_REF_SET);
    localparam logic [15:0] BCAST_ADDR = 16'hFFFF;
    localparam logic [15:0] PERIOD_OFF = 16'h0000;
    localparam logic [2:0] SLEEP_OFF = 3'h0;
    localparam logic [12:0] CTS_PIN_MASK = 13'h0080;
    localparam int RXB_DEPTH = 64;
    localparam int TXB_DEPTH = 64;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_TAKE = 2'b01,
        TX_SKIP = 2'b10
    } iolp_tx_st_t;
endpackage

// ### design/iolp_fifo_mem.sv
// Byte FIFO storage with registered read data
`timescale 1ns/1ps
module iolp_fifo_mem #(
    parameter int W     = 8,
    parameter int DEPTH = 64
) (
    input  wire logic                     clk,     // Core clock
    input  wire logic                     rst_n,   // Async reset
    input  wire logic                     wr_en,   // Write, caller checks full
    input  wire logic [W-1:0]             wr_data, // Write data
    input  wire logic                     rd_en,   // Read, caller checks empty
    output logic      [W-1:0]             rd_data, // Registered read data
    output logic      [$clog2(DEPTH):0]   count    // Words held
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
    end
    logic [W-1:0]  mem_ff [DEPTH];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_ff[wp_ff] <= wr_data;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff   <= '0;
            rp_ff   <= '0;
            count   <= '0;
            rd_data <= '0;
        end else begin
            if (wr_en) wp_ff <= wp_ff + 1'b1;
            if (rd_en) begin
                rp_ff   <= rp_ff + 1'b1;
                rd_data <= mem_ff[rp_ff];
            end
            count <= count + (AW+1)'(wr_en) - (AW+1)'(rd_en);
        end
    end
endmodule

// ### design/iolp_hold_timer.sv
// Per-pin hold timer for passed output levels
`timescale 1ns/1ps
module iolp_hold_timer #(
    parameter int TW = 8
) (
    input  wire logic          clk,    // Core clock
    input  wire logic          rst_n,  // Async reset
    input  wire logic          tick,   // Timeout unit, absent while asleep
    input  wire logic          load,   // Passed sample touched this pin
    input  wire logic [TW-1:0] tmo,    // Timeout in units, zero holds
    output logic               active  // Passed level in force
);
    logic [TW-1:0] cnt_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            active <= 1'b0;
        end else if (load) begin
            cnt_ff <= tmo;
            active <= 1'b1;
        end else if (tick && cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
            if (cnt_ff == TW'(1)) active <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_hold_load: assert property (load |=> active && cnt_ff == $past(tmo))
        else $error("hold not loaded");
    a_hold_pause: assert property (active && !tick && !load |=> active && $stable(cnt_ff))
        else $error("hold timer moved without tick");
    a_hold_end: assert property (tick && !load && cnt_ff == TW'(1) |=> !active)
        else $error("hold did not expire");
endmodule

// ### design/iolp_top.sv
// I/O sampling, line passing and serial buffer control
`timescale 1ns/1ps
module iolp_top import iolp_pkg::*; #(
    parameter int MS_CYCLES = MS_CYC,
    parameter int TW        = 8,
    parameter int RX_DEPTH  = RXB_DEPTH,
    parameter int TX_DEPTH  = TXB_DEPTH
) (
    input  wire logic                    CORE_CLK,                    // Core clock
    input  wire logic                    RESETN,                      // Async reset, low
    input  wire logic [15:0]             SAMPLE_PERIOD,               // Period in ms
    input  wire logic [NPIN-1:0]         CHANGE_MONITOR_MASK,         // Lines watched
    input  wire logic [15:0]             INPUT_SOURCE_ADDRESS,        // Passing source
    input  wire logic                    PASSED_SAMPLE_OUTPUT_ENABLE, // Emit passed
    input  wire logic                    FRAMED_COMMAND_MODE,         // Framed mode
    input  wire logic [2:0]              SLEEP_SETTING,               // Nonzero allows sleep
    input  wire logic                    ASLEEP,                      // Power state
    input  wire logic [31:0]             DESTINATION_ADDRESS_HIGH,    // Dest high
    input  wire logic [31:0]             DESTINATION_ADDRESS_LOW,     // Dest low
    input  wire logic [NPIN*TW-1:0]      PIN_HOLD_TIMEOUT,            // Per pin timeout
    input  wire logic [NPIN-1:0]         OUT_EN_CFG,                  // Pin is output
    input  wire logic [NPIN-1:0]         OUT_LEVEL_CFG,               // Configured level
    input  wire logic [NPIN-1:0]         PERIPH_MASK,                 // UART pins
    input  wire logic [NPIN-1:0]         SPI_MASK,                    // SPI pins
    input  wire logic [NPIN-1:0]         PULL_ENABLE_CONFIG,          // Pull enable
    input  wire logic [NPIN-1:0]         PULL_DIRECTION_CONFIG,       // Pull up
    input  wire logic [NPIN-1:0]         GPIO_IN,                     // Pin levels
    output logic      [NPIN-1:0]         GPIO_OUT,                    // Pin drive level
    output logic      [NPIN-1:0]         GPIO_OE,                     // Pin drive enable
    output logic      [NPIN-1:0]         GPIO_PULL_EN,                // Pull enable
    output logic      [NPIN-1:0]         GPIO_PULL_UP,                // Pull direction
    output logic      [NPIN-1:0]         PERIPH_OVR,                  // Sleep override
    output logic                         SAMPLE_REQ,                  // Send sample pulse
    output logic      [NPIN-1:0]         SAMPLE_DIO,                  // Sampled levels
    output logic      [63:0]             SAMPLE_DEST,                 // Destination
    input  wire logic                    RX_SAMPLE_VALID,             // Sample received
    input  wire logic [15:0]             RX_SAMPLE_SRC,               // Its source
    input  wire logic [NPIN-1:0]         RX_SAMPLE_MASK,              // Its lines
    input  wire logic [NPIN-1:0]         RX_SAMPLE_DIO,               // Its levels
    output logic                         SAMPLE_EMIT,                 // Emit frame pulse
    input  wire logic                    CTS_FLOW_EN,                 // Flow control on
    input  wire logic [7:0]              FLOW_THRESHOLD,              // Bytes
    input  wire logic                    SER_RX_VALID,                // Serial byte in
    input  wire logic [7:0]              SER_RX_DATA,                 // Its value
    input  wire logic                    RXB_POP,                     // Take a byte
    output logic                         RXB_AVAIL,                   // Bytes held
    output logic      [7:0]              RXB_DATA,                    // Popped byte
    output logic                         RXB_DATA_VALID,              // Popped pulse
    output logic                         RXB_DROP,                    // Byte lost pulse
    output logic                         CTS_N,                       // Clear to send, low
    input  wire logic                    RF_PKT_START,                // Packet header
    input  wire logic [15:0]             RF_PKT_LEN,                  // Packet bytes
    input  wire logic                    SYS_BUF_FULL,                // System buffers full
    input  wire logic                    RF_DATA_VALID,               // Packet byte
    input  wire logic [7:0]              RF_DATA,                     // Its value
    input  wire logic                    RF_DATA_LAST,                // Last byte
    output logic                         RF_READY,                    // Room for bytes
    output logic                         RF_PKT_DROP,                 // Packet lost pulse
    input  wire logic                    TXB_POP,                     // Take a byte
    output logic                         TXB_AVAIL,                   // Bytes held
    output logic      [7:0]              TXB_DATA,                    // Popped byte
    output logic                         TXB_DATA_VALID               // Popped pulse
);
    localparam int PW  = $clog2(MS_CYCLES + 1);
    localparam int RCW = $clog2(RX_DEPTH) + 1;
    localparam int TCW = $clog2(TX_DEPTH) + 1;
    initial begin
        if (MS_CYCLES < 1 || TW < 1 || TW > 16 || RCW > 16) $error("bad MS_CYCLES, TW or RX_DEPTH");
        if (HOLD_UNIT_MS * int'(HOLD_REF_SET) != HOLD_REF_MS) $error("bad hold unit");
    end

    // Millisecond and hold unit prescalers, frozen asleep
    logic          slp;
    logic          awake;
    logic [PW-1:0] pre_ff;
    logic [6:0]    unit_ff;
    logic          ms_tick;
    logic          unit_tick;
    assign slp       = ASLEEP && SLEEP_SETTING != SLEEP_OFF;
    assign awake     = !slp;
    assign ms_tick   = awake && pre_ff == PW'(MS_CYCLES - 1);
    assign unit_tick = ms_tick && unit_ff == 7'(HOLD_UNIT_MS - 1);

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pre_ff  <= '0;
            unit_ff <= '0;
        end else if (awake) begin
            pre_ff <= ms_tick ? '0 : pre_ff + 1'b1;
            if (ms_tick) unit_ff <= unit_tick ? '0 : unit_ff + 1'b1;
        end
    end

    // Periodic sampling and wake sample
    logic [15:0] per_ms_ff;
    logic [15:0] per_last_ff;
    logic        slp_ff;
    logic        per_hit;
    logic        per_chg;
    logic        wake_hit;
    assign per_chg  = SAMPLE_PERIOD != per_last_ff;
    assign per_hit  = ms_tick && SAMPLE_PERIOD != PERIOD_OFF
                      && per_ms_ff == SAMPLE_PERIOD - 16'h0001;
    assign wake_hit = slp_ff && awake && SAMPLE_PERIOD != PERIOD_OFF;

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            per_ms_ff   <= '0;
            per_last_ff <= PERIOD_OFF;
            slp_ff      <= 1'b0;
        end else begin
            per_last_ff <= SAMPLE_PERIOD;
            slp_ff      <= slp;
            if (per_chg || per_hit || wake_hit) per_ms_ff <= '0;
            else if (ms_tick) per_ms_ff <= per_ms_ff + 16'h0001;
        end
    end

    // Pin synchronisers and change detection
    logic [NPIN-1:0] in_s1_ff;
    logic [NPIN-1:0] in_s2_ff;
    logic [NPIN-1:0] in_prev_ff;
    logic            chg_any;
    assign chg_any = awake && |((in_s2_ff ^ in_prev_ff) & CHANGE_MONITOR_MASK);

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            in_s1_ff   <= '0;
            in_s2_ff   <= '0;
            in_prev_ff <= '0;
        end else begin
            in_s1_ff   <= GPIO_IN;
            in_s2_ff   <= in_s1_ff;
            in_prev_ff <= in_s2_ff;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            SAMPLE_REQ  <= 1'b0;
            SAMPLE_DIO  <= '0;
            SAMPLE_DEST <= '0;
        end else begin
            SAMPLE_REQ <= per_hit || chg_any || wake_hit;
            if (per_hit || chg_any || wake_hit) begin
                SAMPLE_DIO  <= in_s2_ff;
                SAMPLE_DEST <= {DESTINATION_ADDRESS_HIGH, DESTINATION_ADDRESS_LOW};
            end
        end
    end

    // Received samples: source filter, emission, line passing
    logic            src_match;
    logic            pass_hit;
    logic [NPIN-1:0] gen_out;
    logic [NPIN-1:0] pass_mask;
    logic [NPIN-1:0] pass_lvl_ff;
    logic [NPIN-1:0] hold_act;
    assign src_match = INPUT_SOURCE_ADDRESS == BCAST_ADDR
                       || RX_SAMPLE_SRC == INPUT_SOURCE_ADDRESS;
    assign pass_hit  = RX_SAMPLE_VALID && src_match;
    assign gen_out   = OUT_EN_CFG & ~PERIPH_MASK & ~SPI_MASK;
    assign pass_mask = pass_hit ? (RX_SAMPLE_MASK & gen_out) : '0;

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            SAMPLE_EMIT <= 1'b0;
            pass_lvl_ff <= '0;
        end else begin
            SAMPLE_EMIT <= RX_SAMPLE_VALID && FRAMED_COMMAND_MODE
                           && (!src_match || PASSED_SAMPLE_OUTPUT_ENABLE);
            pass_lvl_ff <= (pass_lvl_ff & ~pass_mask) | (RX_SAMPLE_DIO & pass_mask);
        end
    end

    for (genvar i = 0; i < NPIN; i++) begin : g_hold
        iolp_hold_timer #(.TW(TW)) u_hold (
            .clk    (CORE_CLK),
            .rst_n  (RESETN),
            .tick   (unit_tick),
            .load   (pass_mask[i]),
            .tmo    (PIN_HOLD_TIMEOUT[i*TW +: TW]),
            .active (hold_act[i])
        );
    end

    // Pin drive, including sleep overrides
    logic [NPIN-1:0] lvl;
    logic [NPIN-1:0] ovr;
    logic [NPIN-1:0] in_pin;
    assign lvl    = (hold_act & pass_lvl_ff) | (~hold_act & OUT_LEVEL_CFG);
    assign ovr    = slp ? ((PERIPH_MASK & ~CTS_PIN_MASK) | SPI_MASK) : '0;
    assign in_pin = ~OUT_EN_CFG & ~PERIPH_MASK & ~SPI_MASK;

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            GPIO_OUT     <= '0;
            GPIO_OE      <= '0;
            GPIO_PULL_EN <= '0;
            GPIO_PULL_UP <= '0;
            PERIPH_OVR   <= '0;
        end else begin
            GPIO_OUT     <= (gen_out & lvl) | (ovr & SPI_MASK);
            GPIO_OE      <= gen_out | ovr;
            GPIO_PULL_EN <= PULL_ENABLE_CONFIG & in_pin;
            GPIO_PULL_UP <= PULL_DIRECTION_CONFIG & in_pin;
            PERIPH_OVR   <= ovr;
        end
    end

    // Serial receive buffer and clear-to-send
    logic [RCW-1:0] rx_cnt;
    logic           rx_full;
    logic           rx_wr;
    logic           rx_rd;
    logic           cts_above;
    logic           cts_below;
    assign rx_full = rx_cnt == RCW'(RX_DEPTH);
    assign rx_wr   = SER_RX_VALID && !rx_full;
    assign rx_rd   = RXB_POP && rx_cnt != '0;
    // Compare at 16 bits so a large threshold is not cut to the count width
    assign cts_above = 16'(rx_cnt) > 16'(FLOW_THRESHOLD);
    assign cts_below = 16'(rx_cnt) < 16'(FLOW_THRESHOLD);

    iolp_fifo_mem #(.W(8), .DEPTH(RX_DEPTH)) u_rxb (
        .clk     (CORE_CLK),
        .rst_n   (RESETN),
        .wr_en   (rx_wr),
        .wr_data (SER_RX_DATA),
        .rd_en   (rx_rd),
        .rd_data (RXB_DATA),
        .count   (rx_cnt)
    );

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            RXB_AVAIL      <= 1'b0;
            RXB_DATA_VALID <= 1'b0;
            RXB_DROP       <= 1'b0;
            CTS_N          <= 1'b0;
        end else begin
            RXB_AVAIL      <= rx_cnt != '0;
            RXB_DATA_VALID <= rx_rd;
            RXB_DROP       <= SER_RX_VALID && rx_full;
            if (!CTS_FLOW_EN) CTS_N <= 1'b0;
            else if (cts_above) CTS_N <= 1'b1;
            else if (cts_below) CTS_N <= 1'b0;
        end
    end

    // Radio to serial transmit buffer, whole packet drop
    iolp_tx_st_t    tx_st_ff;
    logic [TCW-1:0] tx_cnt;
    logic           tx_wr;
    logic           tx_rd;
    logic           tx_room;
    assign tx_room = 17'(TX_DEPTH) - 17'(tx_cnt) >= 17'(RF_PKT_LEN);
    assign tx_wr   = tx_st_ff == TX_TAKE && RF_DATA_VALID && tx_cnt != TCW'(TX_DEPTH);
    assign tx_rd   = TXB_POP && tx_cnt != '0;

    iolp_fifo_mem #(.W(8), .DEPTH(TX_DEPTH)) u_txb (
        .clk     (CORE_CLK),
        .rst_n   (RESETN),
        .wr_en   (tx_wr),
        .wr_data (RF_DATA),
        .rd_en   (tx_rd),
        .rd_data (TXB_DATA),
        .count   (tx_cnt)
    );

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            tx_st_ff    <= TX_IDLE;
            RF_PKT_DROP <= 1'b0;
        end else begin
            RF_PKT_DROP <= 1'b0;
            unique case (tx_st_ff)
                TX_IDLE: begin
                    if (RF_PKT_START) begin
                        if (!tx_room && SYS_BUF_FULL) begin
                            tx_st_ff    <= TX_SKIP;
                            RF_PKT_DROP <= 1'b1;
                        end else begin
                            tx_st_ff <= TX_TAKE;
                        end
                    end
                end
                TX_TAKE, TX_SKIP: begin
                    if (RF_DATA_VALID && RF_DATA_LAST) tx_st_ff <= TX_IDLE;
                end
                default: tx_st_ff <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            RF_READY       <= 1'b0;
            TXB_AVAIL      <= 1'b0;
            TXB_DATA_VALID <= 1'b0;
        end else begin
            RF_READY       <= tx_cnt < TCW'(TX_DEPTH - 1);
            TXB_AVAIL      <= tx_cnt != '0;
            TXB_DATA_VALID <= tx_rd;
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    sequence s_rx_pass;
        RX_SAMPLE_VALID && src_match;
    endsequence
    sequence s_rx_other;
        RX_SAMPLE_VALID && !src_match;
    endsequence
    a_period_off: assert property (SAMPLE_PERIOD == PERIOD_OFF && !chg_any |=> !SAMPLE_REQ)
        else $error("periodic sample with period zero");
    a_period_req: assert property (per_hit |=> SAMPLE_REQ && SAMPLE_DEST == $past({DESTINATION_ADDRESS_HIGH,
                                   DESTINATION_ADDRESS_LOW}))
        else $error("periodic sample not sent");
    a_transp_quiet: assert property (!FRAMED_COMMAND_MODE |=> !SAMPLE_EMIT)
        else $error("emit in transparent mode");
    a_change_req: assert property (awake && |((in_s2_ff ^ in_prev_ff) & CHANGE_MONITOR_MASK)
                                   |=> SAMPLE_REQ)
        else $error("change sample missing");
    a_sleep_nochg: assert property (slp |-> !chg_any)
        else $error("change sample asleep");
    a_wake_req: assert property (slp ##1 !slp && SAMPLE_PERIOD != PERIOD_OFF |=> SAMPLE_REQ)
        else $error("no sample on wake");
    a_src_filter: assert property (s_rx_other |=> $stable(pass_lvl_ff))
        else $error("foreign sample drove outputs");
    a_bcast_any: assert property (RX_SAMPLE_VALID && INPUT_SOURCE_ADDRESS == BCAST_ADDR |-> pass_hit)
        else $error("broadcast source refused");
    a_pass_level: assert property (s_rx_pass ##0 (|pass_mask)
                                   |=> ((pass_lvl_ff ^ $past(RX_SAMPLE_DIO)) & $past(pass_mask)) == '0)
        else $error("passed level wrong");
    a_pin_drive: assert property (s_rx_pass ##0 (|pass_mask) |=> ##1 ((GPIO_OUT ^ $past(RX_SAMPLE_DIO, 2))
                                  & $past(pass_mask, 2)) == '0)
        else $error("pin not driven with passed level");
    a_no_periph: assert property ((pass_mask & (PERIPH_MASK | SPI_MASK)) == '0)
        else $error("peripheral pin passed");
    a_iu_hide: assert property (s_rx_pass ##0 !PASSED_SAMPLE_OUTPUT_ENABLE |=> !SAMPLE_EMIT)
        else $error("suppressed sample emitted");
    a_other_emit: assert property (s_rx_other ##0 FRAMED_COMMAND_MODE |=> SAMPLE_EMIT)
        else $error("non matching sample not emitted");
    a_sleep_keep: assert property (slp && !RX_SAMPLE_VALID ##1 slp && $stable(OUT_LEVEL_CFG) && $stable(OUT_EN_CFG)
                                   && $stable(PERIPH_MASK) && $stable(SPI_MASK)
                                   |=> $stable(GPIO_OUT & GPIO_OE & ~PERIPH_OVR))
        else $error("output level moved in sleep");
    a_sleep_spi: assert property (slp |=> (GPIO_OE & GPIO_OUT & $past(SPI_MASK)) == $past(SPI_MASK))
        else $error("SPI pin not high in sleep");
    a_rx_drop: assert property (SER_RX_VALID && rx_full
                                |=> RXB_DROP && rx_cnt == $past(rx_cnt) - RCW'($past(rx_rd)))
        else $error("byte not dropped when full");
    a_cts_off: assert property (CTS_FLOW_EN && cts_above |=> CTS_N)
        else $error("clear to send not withdrawn");
    a_cts_on: assert property (CTS_FLOW_EN && cts_below |=> !CTS_N)
        else $error("clear to send not restored");
    a_pkt_drop: assert property (tx_st_ff == TX_IDLE && RF_PKT_START && !tx_room && SYS_BUF_FULL
                                 |=> RF_PKT_DROP ##0 tx_st_ff == TX_SKIP)
        else $error("packet not dropped");
    a_per_restart: assert property (per_chg |=> per_ms_ff == '0)
        else $error("period counter not restarted");
endmodule

// ### dv/iolp_host_model.sv
// Host model sending serial bytes under clear-to-send
`timescale 1ns/1ps
module iolp_host_model (
    input  wire logic       clk,   // Core clock
    input  wire logic       cts_n, // Clear to send, low
    input  wire logic       go,    // Send when allowed
    input  wire logic       hog,   // Ignore clear-to-send
    output logic            vld,   // Byte strobe
    output logic [7:0]      dat    // Byte value, changes every cycle
);
    initial {vld, dat} = 9'h000;
    always @(negedge clk) begin
        vld <= go && (!cts_n || hog);
        dat <= dat + 8'h01;
    end
endmodule

// ### dv/tb.sv
// Self-checking bench for sampling, line passing and serial buffers
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin errors++; $display("Error %s %0h %0h", n, e, s); end end
module tb import iolp_pkg::*;;
    logic CORE_CLK, RESETN, PASSED_SAMPLE_OUTPUT_ENABLE, FRAMED_COMMAND_MODE, ASLEEP, RX_SAMPLE_VALID, CTS_FLOW_EN, h;
    logic SER_RX_VALID, RXB_POP, RF_PKT_START, SYS_BUF_FULL, RF_DATA_VALID, RF_DATA_LAST, TXB_POP, go, hog;
    logic SAMPLE_REQ, SAMPLE_EMIT, RXB_AVAIL, RXB_DATA_VALID, RXB_DROP, CTS_N, RF_READY, RF_PKT_DROP, TXB_AVAIL;
    logic [15:0] SAMPLE_PERIOD, INPUT_SOURCE_ADDRESS, RX_SAMPLE_SRC, RF_PKT_LEN;
    logic [12:0] CHANGE_MONITOR_MASK, OUT_EN_CFG, OUT_LEVEL_CFG, PERIPH_MASK, SPI_MASK, PULL_ENABLE_CONFIG, GPIO_IN;
    logic [12:0] PULL_DIRECTION_CONFIG, GPIO_OUT, GPIO_OE, GPIO_PULL_EN, GPIO_PULL_UP, PERIPH_OVR, SAMPLE_DIO;
    logic [12:0] RX_SAMPLE_MASK, RX_SAMPLE_DIO;
    logic [2:0]  SLEEP_SETTING;
    logic [31:0] DESTINATION_ADDRESS_HIGH, DESTINATION_ADDRESS_LOW;
    logic [63:0] SAMPLE_DEST;
    logic [103:0] PIN_HOLD_TIMEOUT;
    logic [7:0]  FLOW_THRESHOLD, SER_RX_DATA, RXB_DATA, RF_DATA, TXB_DATA, r;
    logic        TXB_DATA_VALID;
    int          errors, checks_done, drops, pops;
    logic [7:0]  exp_b, q[$];
    logic        full_b;
    iolp_top #(.MS_CYCLES(4)) uut (.*);
    iolp_host_model host (.clk(CORE_CLK), .cts_n(CTS_N), .go(go), .hog(hog), .vld(SER_RX_VALID), .dat(SER_RX_DATA));
    initial begin
        CORE_CLK = 1'b0;
        forever #4 CORE_CLK = ~CORE_CLK;
    end
    // Mirror of the receive buffer: full is judged before this edge's pop
    always @(posedge CORE_CLK) begin
        full_b = q.size() == RXB_DEPTH;
        if (RXB_POP && q.size() > 0) exp_b = q.pop_front();
        if (SER_RX_VALID && !full_b) q.push_back(SER_RX_DATA);
    end
    always @(negedge CORE_CLK) begin
        drops += (RXB_DROP === 1'b1);
        pops += (RXB_DATA_VALID === 1'b1);
        if (RXB_DATA_VALID === 1'b1) `CHK("rxbyte", exp_b, RXB_DATA)
    end
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic wt(input int n);
        h = 1'b0;
        repeat (n) @(posedge CORE_CLK) #1 h |= (SAMPLE_REQ === 1'b1);
    endtask
    task automatic rx(input logic [15:0] s, input logic f, u, e, input logic [12:0] p);
        @(negedge CORE_CLK) {RX_SAMPLE_VALID, RX_SAMPLE_SRC, FRAMED_COMMAND_MODE, PASSED_SAMPLE_OUTPUT_ENABLE} = {1'b1, s, f, u};
        @(negedge CORE_CLK) RX_SAMPLE_VALID = 1'b0;
        `CHK("emit", e, SAMPLE_EMIT)
        @(negedge CORE_CLK) `CHK("pass", p, GPIO_OUT & 13'h1007)
    endtask
    task automatic rf(input logic [15:0] n, input logic f, e);
        @(negedge CORE_CLK) {RF_PKT_START, RF_PKT_LEN, SYS_BUF_FULL} = {1'b1, n, f};
        @(negedge CORE_CLK) {RF_PKT_START, RF_DATA_VALID, RF_DATA_LAST, RF_DATA} = {3'h3, r};
        `CHK("rfdrop", e, RF_PKT_DROP)
        @(negedge CORE_CLK) {RF_DATA_VALID, RF_DATA_LAST} = 2'h0;
    endtask
    task automatic wrap_up;
        if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        {RESETN, ASLEEP, RX_SAMPLE_VALID, RXB_POP, RF_PKT_START, RF_DATA_VALID, RF_DATA_LAST, TXB_POP, go, hog} = 0;
        {SYS_BUF_FULL, SAMPLE_PERIOD, CHANGE_MONITOR_MASK, GPIO_IN, SLEEP_SETTING, RX_SAMPLE_SRC, RF_PKT_LEN, RF_DATA} = 0;
        {PASSED_SAMPLE_OUTPUT_ENABLE, FRAMED_COMMAND_MODE, CTS_FLOW_EN, FLOW_THRESHOLD} = {3'h7, 8'h08};
        {OUT_EN_CFG, OUT_LEVEL_CFG, PERIPH_MASK, SPI_MASK} = {13'h0005, 13'h0005, 13'h0083, 13'h1000};
        {PULL_ENABLE_CONFIG, PULL_DIRECTION_CONFIG, RX_SAMPLE_MASK, RX_SAMPLE_DIO} = {13'h0010, 13'h0010, 13'h1fff, 13'h1003};
        PIN_HOLD_TIMEOUT = {13{8'h02}};
        r = lfsr(8'h58);
        {DESTINATION_ADDRESS_HIGH, DESTINATION_ADDRESS_LOW, INPUT_SOURCE_ADDRESS} = {{7{r}}, 8'h00, 8'h00, r};
        repeat (5) @(negedge CORE_CLK);
        RESETN = 1'b1;
        repeat (2) @(negedge CORE_CLK);
        wt(40);
        `CHK("idle", 1'b0, h)
        @(negedge CORE_CLK) SAMPLE_PERIOD = 16'h0002;
        wt(20);
        `CHK("periodic", 1'b1, h)
        `CHK("dest", {{7{r}}, 8'h00}, SAMPLE_DEST)
        @(negedge CORE_CLK) {SAMPLE_PERIOD, CHANGE_MONITOR_MASK} = {16'h0000, 13'h0008};
        repeat (4) @(negedge CORE_CLK);
        GPIO_IN = 13'h0008;
        wt(6);
        `CHK("change", 1'b1, h)
        `CHK("level", 13'h0008, SAMPLE_DIO & 13'h0008)
        @(negedge CORE_CLK) {SLEEP_SETTING, ASLEEP} = 4'h3;
        repeat (2) @(negedge CORE_CLK);
        GPIO_IN = 13'h0000;
        wt(10);
        `CHK("asleep", 1'b0, h)
        `CHK("outhold", 13'h0004, GPIO_OUT & 13'h0004)
        `CHK("sleepio", 5'h19, {GPIO_OUT[12], GPIO_OE[12], GPIO_OUT[1], PERIPH_OVR[7], GPIO_PULL_UP[4]})
        `CHK("pullen", 1'b1, GPIO_PULL_EN[4])
        @(negedge CORE_CLK) {SAMPLE_PERIOD, ASLEEP} = {16'h0064, 1'b0};
        wt(4);
        `CHK("wake", 1'b1, h)
        @(negedge CORE_CLK) SAMPLE_PERIOD = 16'h0000;
        rx(~INPUT_SOURCE_ADDRESS, 1'b1, 1'b0, 1'b1, 13'h0004);
        rx(INPUT_SOURCE_ADDRESS, 1'b1, 1'b1, 1'b1, 13'h0000);
        rx(INPUT_SOURCE_ADDRESS, 1'b1, 1'b0, 1'b0, 13'h0000);
        rx(INPUT_SOURCE_ADDRESS, 1'b0, 1'b1, 1'b0, 13'h0000);
        // Two hold units: expiry lands between 401 and 800 cycles after the load
        repeat (280) @(negedge CORE_CLK);
        `CHK("held", 13'h0000, GPIO_OUT & 13'h0005)
        repeat (530) @(negedge CORE_CLK);
        `CHK("revert", 13'h0004, GPIO_OUT & 13'h0005)
        INPUT_SOURCE_ADDRESS = BCAST_ADDR;
        rx({r, r}, 1'b0, 1'b1, 1'b0, 13'h0000);
        go <= 1'b1;
        repeat (60) @(negedge CORE_CLK);
        `CHK("ctsoff", 1'b1, CTS_N)
        `CHK("lossless", 0, drops)
        hog <= 1'b1;
        repeat (80) @(negedge CORE_CLK);
        `CHK("full", 1'b1, drops > 0)
        {go, hog, RXB_POP} <= 3'h1;
        repeat (70) @(negedge CORE_CLK);
        `CHK("ctson", 1'b0, CTS_N)
        `CHK("empty", 1'b0, RXB_AVAIL)
        `CHK("pops", RXB_DEPTH, pops)
        RXB_POP = 1'b0;
        `CHK("ready", 1'b1, RF_READY)
        r = lfsr(r);
        rf(16'h0046, 1'b1, 1'b1);
        rf(16'h0001, 1'b0, 1'b0);
        repeat (3) @(negedge CORE_CLK);
        TXB_POP = 1'b1;
        @(negedge CORE_CLK) TXB_POP = 1'b0;
        `CHK("txbyte", r, TXB_DATA)
        `CHK("txvld", 1'b1, TXB_DATA_VALID)
        @(negedge CORE_CLK) `CHK("txempty", 1'b0, TXB_AVAIL)
        wrap_up();
    end
endmodule
